// ### common/audio_ctrl_pkg.sv
// holds the offsets, field layout, reset values and ramp constants of the block
// assumes 8-bit registers reached by 8-bit offsets over the control port
package audio_ctrl_pkg;
  // register offsets on the control port
  localparam logic [7:0] EMERG_RAMP_OFFSET = 8'h40;
  localparam logic [7:0] AUTO_MUTE_OFFSET = 8'h41;
  localparam logic [7:0] DITHER_GAIN_OFFSET = 8'h43;
  localparam logic [7:0] DC_HIGH_OFFSET = 8'h44;
  localparam logic [7:0] DC_LOW_OFFSET = 8'h45;
  // register storage indices
  localparam int NUM_REGS = 5;
  localparam logic [2:0] IDX_EMERG = 3'h0;
  localparam logic [2:0] IDX_AUTO_MUTE = 3'h1;
  localparam logic [2:0] IDX_DITHER = 3'h2;
  localparam logic [2:0] IDX_DC_HIGH = 3'h3;
  localparam logic [2:0] IDX_DC_LOW = 3'h4;
  localparam logic [7:0] REG_OFFSETS [NUM_REGS] = '{8'h40, 8'h41, 8'h43, 8'h44, 8'h45};
  // reset values, reserved bits clear
  localparam logic [7:0] REG_RESETS [NUM_REGS] = '{8'h10, 8'h07, 8'h00, 8'h00, 8'h00};
  // field positions
  localparam int RATE_LSB = 6;
  localparam int STEP_LSB = 4;
  localparam int POLICY_BIT = 2;
  localparam int RIGHT_EN_BIT = 1;
  localparam int LEFT_EN_BIT = 0;
  localparam int LEFT_AC_LSB = 6;
  localparam int RIGHT_AC_LSB = 4;
  localparam int LEFT_DEM_LSB = 2;
  localparam int RIGHT_DEM_LSB = 0;
  localparam int DC_HIGH_W = 3;
  localparam int DC_W = 11;
  // modulator word and dither scaling: 2^23 * 2^-5 * 2^-11
  localparam int MOD_W = 24;
  localparam int DC_SHIFT = 7;
  localparam int DC_PAD = MOD_W - DC_W - DC_SHIFT;
  localparam logic [MOD_W-1:0] MOD_POS_MAX = 24'h7fffff;
  // ramp rate codes and frame counts
  localparam logic [1:0] RATE_INSTANT = 2'h3;
  localparam logic [2:0] FRAMES_CODE0 = 3'h1;
  localparam logic [2:0] FRAMES_CODE1 = 3'h2;
  localparam logic [2:0] FRAMES_CODE2 = 3'h4;
  // attenuation in 0.5 dB units, top code is mute
  localparam logic [7:0] STEP_4DB = 8'h08;
  localparam logic [7:0] STEP_2DB = 8'h04;
  localparam logic [7:0] STEP_1DB = 8'h02;
  localparam logic [7:0] STEP_HALF_DB = 8'h01;
  localparam logic [7:0] ATTEN_NONE = 8'h00;
  localparam logic [7:0] ATTEN_MUTE = 8'hff;

  typedef enum logic [2:0] {
    RAMP_IDLE = 3'b001,
    RAMP_DOWN = 3'b010,
    RAMP_MUTED = 3'b100
  } ramp_state_t;

  // step code to half-dB decrement
  function automatic logic [7:0] step_halfdb(input logic [1:0] code);
    unique case (code)
      2'h0: step_halfdb = STEP_4DB;
      2'h1: step_halfdb = STEP_2DB;
      2'h2: step_halfdb = STEP_1DB;
      2'h3: step_halfdb = STEP_HALF_DB;
    endcase
  endfunction

  // rate code to frames per update
  function automatic logic [2:0] rate_frames(input logic [1:0] code);
    unique case (code)
      2'h0: rate_frames = FRAMES_CODE0;
      2'h1: rate_frames = FRAMES_CODE1;
      2'h2: rate_frames = FRAMES_CODE2;
      2'h3: rate_frames = FRAMES_CODE0;
    endcase
  endfunction
endpackage

// ### common/mute_ctrl_if.sv
// carries the applied ramp and auto-mute settings between the register bank and its users
// assumes one driver, the register bank
`timescale 1ns/1ps
interface mute_ctrl_if;
  logic [1:0] ramp_rate; // emergency update rate code
  logic [1:0] ramp_step; // emergency step code
  logic policy; // 1: mute both only together
  logic left_en; // left auto-mute enable
  logic right_en; // right auto-mute enable
  modport source(output ramp_rate, output ramp_step, output policy, output left_en, output right_en);
  modport sink(input ramp_rate, input ramp_step, input policy, input left_en, input right_en);
endinterface

// ### tb/volume_mute_dither_regs_props.sv
// checker for the register slice: read port, ramp engine, auto-mute and dither path
// assumes it is bound to the top module and sees only that module's ports
`timescale 1ns/1ps
module volume_mute_dither_regs_props
  import audio_ctrl_pkg::*;
(
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic fs_tick_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic reg_hit_o,
  input wire logic clock_error_i,
  input wire logic power_outage_i,
  input wire logic soft_mute_i,
  input wire logic [7:0] attenuation_o,
  input wire logic ramp_active_o,
  input wire logic left_zero_i,
  input wire logic right_zero_i,
  input wire logic left_auto_mute_o,
  input wire logic right_auto_mute_o,
  input wire logic [DC_W-1:0] left_primary_dc_dither_o,
  input wire logic [MOD_W-1:0] left_mod_i,
  input wire logic [MOD_W-1:0] left_mod_o
);
  // sum widened one bit so a positive overflow is visible
  wire logic signed [MOD_W:0] mod_sum_w = $signed({left_mod_i[MOD_W-1], left_mod_i})
    + $signed({2'b00, left_primary_dc_dither_o, {DC_SHIFT{1'b0}}});
  // saturated expectation, only the positive side can overflow
  wire logic [MOD_W-1:0] mod_exp_w = (mod_sum_w > 25'sh07fffff) ? MOD_POS_MAX : mod_sum_w[MOD_W-1:0];
  // offsets the read port answers
  wire logic mapped_w = reg_addr_i inside {EMERG_RAMP_OFFSET, AUTO_MUTE_OFFSET, DITHER_GAIN_OFFSET,
    DC_HIGH_OFFSET, DC_LOW_OFFSET};
  wire logic any_req_w = clock_error_i | power_outage_i | soft_mute_i; // any ramp trigger
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  // two cycles with every ramp trigger low
  sequence quiet_s;
    !any_req_w ##1 !any_req_w;
  endsequence
  // read strobe toward a hole in the map
  sequence unmapped_rd_s;
    reg_rd_i && !mapped_w;
  endsequence
  read_unmapped_a: assert property (unmapped_rd_s |=> reg_rdata_o == 8'h00 && !reg_hit_o)
    else $error("unmapped read returned data");
  read_hit_a: assert property (reg_rd_i && mapped_w |=> reg_hit_o)
    else $error("mapped read not flagged");
  rdata_hold_a: assert property (!reg_rd_i |=> $stable(reg_rdata_o) && $stable(reg_hit_o))
    else $error("read data moved without strobe");
  ramp_start_a: assert property (any_req_w |=> ramp_active_o)
    else $error("ramp request not taken");
  ramp_release_a: assert property (quiet_s |-> attenuation_o == ATTEN_NONE && !ramp_active_o)
    else $error("volume not restored after release");
  ramp_step_a: assert property (attenuation_o > $past(attenuation_o) |-> attenuation_o == ATTEN_MUTE
    || (attenuation_o - $past(attenuation_o)) inside {8'h01, 8'h02, 8'h04, 8'h08})
    else $error("illegal attenuation step");
  left_needs_zero_a: assert property (fs_tick_i && !left_zero_i |=> !left_auto_mute_o)
    else $error("left muted without zero run");
  right_needs_zero_a: assert property (fs_tick_i && !right_zero_i |=> !right_auto_mute_o)
    else $error("right muted without zero run");
  mute_hold_a: assert property (!fs_tick_i |=> $stable(left_auto_mute_o) && $stable(right_auto_mute_o))
    else $error("auto mute moved between frames");
  dc_path_a: assert property (1'b1 |=> left_mod_o == $past(mod_exp_w))
    else $error("dither sum wrong");
endmodule

bind volume_mute_dither_regs volume_mute_dither_regs_props volume_mute_dither_regs_props_inst (.clock_i,
  .resetn_i, .fs_tick_i, .reg_rd_i, .reg_addr_i, .reg_rdata_o, .reg_hit_o, .clock_error_i, .power_outage_i,
  .soft_mute_i, .attenuation_o, .ramp_active_o, .left_zero_i, .right_zero_i, .left_auto_mute_o,
  .right_auto_mute_o, .left_primary_dc_dither_o, .left_mod_i, .left_mod_o);

// ### tb/volume_mute_dither_regs_tb.sv
// self-checking bench for the register slice, register rows first, then hand tests
// assumes the checker is bound in separately; normal ramp codes are driven by the bench
`timescale 1ns/1ps
module volume_mute_dither_regs_tb;
  import audio_ctrl_pkg::*;
  typedef struct {logic [7:0] addr; logic [7:0] wdata; logic [7:0] rdata; logic hit;} row_t;
  logic clock_i, resetn_i, fs_tick_i, reg_wr_i, reg_rd_i, reg_hit_o, clock_error_i, power_outage_i;
  logic soft_mute_i, ramp_active_o, left_zero_i, right_zero_i, left_auto_mute_o, right_auto_mute_o;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, attenuation_o;
  logic [1:0] ac_l, ac_r, dem_l, dem_r; // applied gain fields
  logic [DC_W-1:0] dc_o;
  logic [MOD_W-1:0] left_mod_i, left_mod_o;
  logic exl, exr; // expected mutes
  logic [1:0] nrate, nstep; // normal soft-mute codes
  int n_mismatch = 0;
  int n_tests = 0;
  // write then read rows; reserved bits written as ones to see them stick
  row_t rows [6] = '{'{8'h40, 8'hcf, 8'hcf, 1'b1}, '{8'h41, 8'hfa, 8'hfa, 1'b1}, '{8'h43, 8'h55, 8'h55, 1'b1},
    '{8'h44, 8'hff, 8'hff, 1'b1}, '{8'h45, 8'h81, 8'h81, 1'b1}, '{8'h42, 8'h5a, 8'h00, 1'b0}};
  logic [7:0] rst_vals [5] = '{8'h10, 8'h07, 8'h00, 8'h00, 8'h00}; // step code one, mutes on
  volume_mute_dither_regs volume_mute_dither_regs_inst (.clock_i(clock_i), .resetn_i(resetn_i),
    .fs_tick_i(fs_tick_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .reg_hit_o(reg_hit_o), .clock_error_i(clock_error_i),
    .power_outage_i(power_outage_i), .soft_mute_i(soft_mute_i), .normal_ramp_rate_i(nrate),
    .normal_ramp_step_i(nstep), .attenuation_o(attenuation_o), .ramp_active_o(ramp_active_o),
    .left_zero_i(left_zero_i), .right_zero_i(right_zero_i), .left_auto_mute_o(left_auto_mute_o),
    .right_auto_mute_o(right_auto_mute_o), .left_primary_ac_dither_gain_o(ac_l),
    .right_primary_ac_dither_gain_o(ac_r), .left_primary_dem_dither_gain_o(dem_l),
    .right_primary_dem_dither_gain_o(dem_r), .left_primary_dc_dither_o(dc_o), .left_mod_i(left_mod_i),
    .left_mod_o(left_mod_o));
  // free-running 250 MHz clock
  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  // let n edges pass, then step off the edge so outputs are settled
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  // single compare for every kind of value, zero-extended
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
  endtask
  // read strobe, answer settled one edge later
  task automatic rdchk(input logic [7:0] a, input logic [7:0] d, input logic h);
    @(posedge clock_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    #1;
    chk(reg_rdata_o, d);
    chk(reg_hit_o, h);
  endtask
  // one frame tick; settings are copied at its sampling edge
  task automatic tick();
    @(posedge clock_i);
    fs_tick_i <= 1'b1;
    @(posedge clock_i);
    fs_tick_i <= 1'b0;
    #1;
  endtask
  task automatic do_reset();
    @(posedge clock_i);
    resetn_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    resetn_i <= 1'b1;
  endtask
  // emergency ramp with a given setting, n frames, then release
  task automatic ramp(input logic [7:0] cfg, input logic po, input int n, input logic [7:0] exp);
    wr(EMERG_RAMP_OFFSET, cfg);
    tick();
    @(posedge clock_i);
    clock_error_i <= ~po;
    power_outage_i <= po;
    cyc(2);
    repeat (n) tick();
    cyc(2);
    chk(attenuation_o, exp);
    chk(ramp_active_o, 1'b1);
    @(posedge clock_i);
    clock_error_i <= 1'b0;
    power_outage_i <= 1'b0;
    cyc(2);
    chk(attenuation_o, ATTEN_NONE);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    {resetn_i, fs_tick_i, reg_wr_i, reg_rd_i, clock_error_i, power_outage_i, soft_mute_i} = 7'h00;
    {left_zero_i, right_zero_i, reg_addr_i, reg_wdata_i, left_mod_i} = '0;
    {nrate, nstep} = 4'hc; // instant normal mute, 4 dB step
    repeat (3) @(posedge clock_i);
    resetn_i <= 1'b1;
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wdata);
      rdchk(rows[i].addr, rows[i].rdata, rows[i].hit);
    end
    $display("register rows done");
    do_reset();
    foreach (rst_vals[i]) rdchk(REG_OFFSETS[i], rst_vals[i], 1'b1);
    chk({attenuation_o, dc_o}, 19'h0);
    $display("reset test done");
    // every policy, enable and zero combination
    for (int i = 0; i < 32; i++) begin
      wr(AUTO_MUTE_OFFSET, {5'h00, i[4:2]});
      @(posedge clock_i);
      left_zero_i <= i[1];
      right_zero_i <= i[0];
      tick();
      tick();
      exl = i[4] ? (i[1] & i[2] & i[0] & i[3]) : (i[1] & i[2]);
      exr = i[4] ? exl : (i[0] & i[3]);
      chk({left_auto_mute_o, right_auto_mute_o}, {exl, exr});
    end
    $display("auto mute test done");
    for (int r = 0; r < 4; r++) ramp({r[1:0], 6'h30}, 1'b0, 4, (r == 3) ? ATTEN_MUTE : 8'h04 >> r);
    for (int s = 0; s < 4; s++) ramp({2'h0, s[1:0], 4'h0}, 1'b1, 1, 8'h08 >> s);
    // soft mute alone follows the normal codes: instant first, then 2 dB per frame
    for (int m = 0; m < 2; m++) begin
      @(posedge clock_i);
      {nrate, nstep} <= (m == 1) ? 4'h1 : 4'hc;
      soft_mute_i <= 1'b1;
      cyc(2);
      repeat (2) tick();
      cyc(1);
      chk(attenuation_o, (m == 1) ? STEP_2DB + STEP_2DB : ATTEN_MUTE);
      @(posedge clock_i);
      soft_mute_i <= 1'b0;
      cyc(2);
      chk(attenuation_o, ATTEN_NONE);
    end
    // with both triggers up the emergency codes win, half a dB per frame here
    @(posedge clock_i);
    soft_mute_i <= 1'b1;
    power_outage_i <= 1'b1;
    cyc(2);
    tick();
    cyc(1);
    chk(attenuation_o, STEP_HALF_DB);
    @(posedge clock_i);
    soft_mute_i <= 1'b0;
    power_outage_i <= 1'b0;
    cyc(2);
    $display("ramp test done");
    wr(DC_HIGH_OFFSET, 8'hfd);
    wr(DC_LOW_OFFSET, 8'ha3);
    wr(DITHER_GAIN_OFFSET, 8'h54);
    @(posedge clock_i);
    left_mod_i <= 24'h001000;
    tick();
    cyc(1);
    chk(dc_o, 11'h5a3);
    chk({ac_l, ac_r, dem_l, dem_r}, 8'h54);
    chk(left_mod_o, 24'h02e180);
    @(posedge clock_i);
    left_mod_i <= 24'h7fff00;
    cyc(2);
    chk(left_mod_o, MOD_POS_MAX);
    @(posedge clock_i);
    left_mod_i <= 24'hff0000;
    cyc(2);
    chk(left_mod_o, 24'h01d180);
    $display("dither test done");
    conclude();
  end
endmodule

// ### verilog/auto_mute.sv
// zero-sample auto-mute decision per channel, applied once per frame
// assumes the zero flags already reflect the configured detection length
`timescale 1ns/1ps
module auto_mute (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic fs_tick_i,
  mute_ctrl_if.sink ctrl,
  input wire logic left_zero_i,
  input wire logic right_zero_i,
  output logic left_mute_o,
  output logic right_mute_o
);
  logic left_mute_reg; // applied left mute
  logic right_mute_reg; // applied right mute

  // a channel qualifies only if enabled
  wire left_ok = left_zero_i & ctrl.left_en;
  wire right_ok = right_zero_i & ctrl.right_en;
  // joint mode needs both; a disabled side blocks the other
  wire both_ok = left_ok & right_ok;
  wire left_next = ctrl.policy ? both_ok : left_ok;
  wire right_next = ctrl.policy ? both_ok : right_ok;

  // decision moves on the frame boundary only
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      left_mute_reg <= 1'b0;
      right_mute_reg <= 1'b0;
    end else if (fs_tick_i) begin
      left_mute_reg <= left_next;
      right_mute_reg <= right_next;
    end
  end

  assign left_mute_o = left_mute_reg;
  assign right_mute_o = right_mute_reg;
endmodule

// ### verilog/emergency_ramp.sv
// volume ramp-down engine, emergency or normal soft-mute settings
// assumes fs_tick_i is a one-cycle pulse per frame period
`timescale 1ns/1ps
module emergency_ramp (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic fs_tick_i,
  mute_ctrl_if.sink ctrl,
  input wire logic clock_error_i,
  input wire logic power_outage_i,
  input wire logic soft_mute_i,
  input wire logic [1:0] normal_rate_i,
  input wire logic [1:0] normal_step_i,
  output logic [7:0] attenuation_o,
  output logic ramp_active_o
);
  import audio_ctrl_pkg::*;

  ramp_state_t state_reg, state_next;
  logic [7:0] atten_reg, atten_next; // attenuation in half dB
  logic [2:0] count_reg, count_next; // frames since last update

  // emergency settings win over the normal ones
  wire emergency = clock_error_i | power_outage_i;
  wire request = emergency | soft_mute_i;
  wire [1:0] sel_rate = emergency ? ctrl.ramp_rate : normal_rate_i;
  wire [1:0] sel_step = emergency ? ctrl.ramp_step : normal_step_i;
  wire [2:0] frames = rate_frames(sel_rate);
  wire [7:0] step = step_halfdb(sel_step);
  wire [8:0] sum = {1'b0, atten_reg} + {1'b0, step};
  wire [7:0] stepped = sum[8] ? ATTEN_MUTE : sum[7:0]; // saturate at mute
  wire due = fs_tick_i && (count_reg == frames - 3'h1);
  wire instant = sel_rate == RATE_INSTANT;

  // next state; release restores full volume at once
  always_comb begin
    state_next = state_reg;
    atten_next = atten_reg;
    count_next = count_reg;
    unique case (state_reg)
      RAMP_IDLE: begin
        count_next = 3'h0;
        if (request) begin
          state_next = RAMP_DOWN;
        end
      end
      RAMP_DOWN: begin
        if (!request) begin
          state_next = RAMP_IDLE;
          atten_next = ATTEN_NONE;
        end else if (fs_tick_i && instant) begin
          state_next = RAMP_MUTED;
          atten_next = ATTEN_MUTE;
        end else if (due) begin
          count_next = 3'h0;
          atten_next = stepped;
          if (stepped == ATTEN_MUTE) begin
            state_next = RAMP_MUTED;
          end
        end else if (fs_tick_i) begin
          count_next = count_reg + 3'h1;
        end
      end
      RAMP_MUTED: begin
        if (!request) begin
          state_next = RAMP_IDLE;
          atten_next = ATTEN_NONE;
        end
      end
      default: begin
        state_next = RAMP_IDLE;
        atten_next = ATTEN_NONE;
      end
    endcase
  end

  // state flops
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= RAMP_IDLE;
      atten_reg <= ATTEN_NONE;
      count_reg <= 3'h0;
    end else begin
      state_reg <= state_next;
      atten_reg <= atten_next;
      count_reg <= count_next;
    end
  end

  assign attenuation_o = atten_reg;
  assign ramp_active_o = state_reg != RAMP_IDLE;
endmodule

// ### verilog/volume_mute_dither_regs.sv
// register slice for emergency volume ramp, auto-mute policy and primary dither
// assumes a simple synchronous control port and a one-cycle frame tick
`timescale 1ns/1ps

// Behaviour
// - rate code sets frames per update, 11 mutes
// - clock error or outage uses emergency settings
// - step code sets 4, 2, 1, 0.5 dB
// - step field resets to code one
// - zero samples auto-mute; policy resets to one
// - policy zero: channels mute independently
// - policy one: mute only when both qualify
// - zero length comes from another register
// - bit one enables right auto-mute
// - bit zero enables left auto-mute
// - joint mode, right disabled: left never mutes
// - joint mode, left disabled: right never mutes
// - left ac dither gain field, bits 7-6
// - right ac dither gain field, bits 5-4
// - left dem dither gain field, bits 3-2
// - right dem dither gain field, bits 1-0
// - dc dither is unsigned q0.11, resets zero
// - dc dither added to left modulator low bits
// - dc dither: three bits plus full byte
module volume_mute_dither_regs (
  input wire logic clock_i,
  input wire logic resetn_i,
  // frame rate tick
  input wire logic fs_tick_i,
  // control port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_hit_o,
  // ramp triggers and normal soft-mute settings
  input wire logic clock_error_i,
  input wire logic power_outage_i,
  input wire logic soft_mute_i,
  input wire logic [1:0] normal_ramp_rate_i,
  input wire logic [1:0] normal_ramp_step_i,
  output logic [7:0] attenuation_o,
  output logic ramp_active_o,
  // zero detection, length set elsewhere
  input wire logic left_zero_i,
  input wire logic right_zero_i,
  output logic left_auto_mute_o,
  output logic right_auto_mute_o,
  // dither settings toward the modulators
  output logic [1:0] left_primary_ac_dither_gain_o,
  output logic [1:0] right_primary_ac_dither_gain_o,
  output logic [1:0] left_primary_dem_dither_gain_o,
  output logic [1:0] right_primary_dem_dither_gain_o,
  output logic [audio_ctrl_pkg::DC_W-1:0] left_primary_dc_dither_o,
  // left primary modulator input path
  input wire logic [audio_ctrl_pkg::MOD_W-1:0] left_mod_i,
  output logic [audio_ctrl_pkg::MOD_W-1:0] left_mod_o
);
  import audio_ctrl_pkg::*;

  // offset lookup, shared by write and read paths
  // bit 3 of the result flags a hit, the low bits carry the storage index
  // a linear search is cheap for five entries and keeps the map in one table
  function automatic logic [3:0] reg_lookup(input logic [7:0] addr);
    logic [3:0] hit_idx;
    hit_idx = 4'h0;
    for (int k = 0; k < NUM_REGS; k++) begin
      if (addr == REG_OFFSETS[k]) begin
        hit_idx = {1'b1, 3'(k)};
      end
    end
    return hit_idx;
  endfunction

  logic [7:0] regs_reg [NUM_REGS]; // software-visible storage
  logic [7:0] applied_reg [NUM_REGS]; // copies that steer the datapath
  logic [7:0] rdata_reg; // read data
  logic hit_reg; // last read landed on a register
  logic [MOD_W-1:0] mod_reg; // dithered modulator word
  mute_ctrl_if ctrl_bus(); // applied settings to the engines

  // address decode
  // write and read share one address bus, so both decode the same offset
  wire [3:0] wr_lookup = reg_lookup(reg_addr_i);
  wire wr_hit = wr_lookup[3];
  wire [2:0] wr_idx = wr_lookup[2:0];
  wire [3:0] rd_lookup = reg_lookup(reg_addr_i);
  wire rd_hit = rd_lookup[3];
  wire [2:0] rd_idx = rd_lookup[2:0];
  wire [7:0] rd_value = rd_hit ? regs_reg[rd_idx] : 8'h00; // unmapped reads zero

  // storage and applied copies, one pair per register
  // reserved bits are kept whole and simply never decoded
  genvar gi;
  generate
    for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
      // software write lands at once
      always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
          regs_reg[gi] <= REG_RESETS[gi];
        end else if (reg_wr_i && wr_hit && wr_idx == 3'(gi)) begin
          regs_reg[gi] <= reg_wdata_i;
        end
      end
      // settings take effect on the next frame tick so a frame never
      // sees a setting change partway through
      always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
          applied_reg[gi] <= REG_RESETS[gi];
        end else if (fs_tick_i) begin
          applied_reg[gi] <= regs_reg[gi];
        end
      end
    end
  endgenerate

  // read port, registered one cycle after the strobe
  // data holds until the next strobe, so a slow master may take it late
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_reg <= 8'h00;
      hit_reg <= 1'b0;
    end else if (reg_rd_i) begin
      rdata_reg <= rd_value;
      hit_reg <= rd_hit;
    end
  end

  assign reg_rdata_o = rdata_reg;
  assign reg_hit_o = hit_reg;

  // field extraction from the applied copies
  wire [7:0] emerg_value = applied_reg[IDX_EMERG];
  wire [7:0] mute_value = applied_reg[IDX_AUTO_MUTE];
  wire [7:0] gain_value = applied_reg[IDX_DITHER];
  wire [7:0] dc_high_value = applied_reg[IDX_DC_HIGH];
  wire [7:0] dc_low_value = applied_reg[IDX_DC_LOW];

  // ramp and auto-mute settings onto the carrier
  assign ctrl_bus.ramp_rate = emerg_value[RATE_LSB +: 2];
  assign ctrl_bus.ramp_step = emerg_value[STEP_LSB +: 2];
  assign ctrl_bus.policy = mute_value[POLICY_BIT];
  assign ctrl_bus.right_en = mute_value[RIGHT_EN_BIT];
  assign ctrl_bus.left_en = mute_value[LEFT_EN_BIT];

  // ramp engine picks emergency or normal settings itself
  emergency_ramp u_ramp (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .fs_tick_i(fs_tick_i),
    .ctrl(ctrl_bus.sink),
    .clock_error_i(clock_error_i),
    .power_outage_i(power_outage_i),
    .soft_mute_i(soft_mute_i),
    .normal_rate_i(normal_ramp_rate_i),
    .normal_step_i(normal_ramp_step_i),
    .attenuation_o(attenuation_o),
    .ramp_active_o(ramp_active_o)
  );

  // zero flags already carry the detection length
  auto_mute u_auto_mute (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .fs_tick_i(fs_tick_i),
    .ctrl(ctrl_bus.sink),
    .left_zero_i(left_zero_i),
    .right_zero_i(right_zero_i),
    .left_mute_o(left_auto_mute_o),
    .right_mute_o(right_auto_mute_o)
  );

  // dither gain codes pass straight through; dem codes above 01
  // are not guarded, software keeps to the legal pair
  assign left_primary_ac_dither_gain_o = gain_value[LEFT_AC_LSB +: 2];
  assign right_primary_ac_dither_gain_o = gain_value[RIGHT_AC_LSB +: 2];
  assign left_primary_dem_dither_gain_o = gain_value[LEFT_DEM_LSB +: 2];
  assign right_primary_dem_dither_gain_o = gain_value[RIGHT_DEM_LSB +: 2];

  // dc dither word: upper three bits from the first register
  // both bytes are copied on the frame tick; software must write both
  // before that tick, or one frame sees a mixed word
  wire [DC_W-1:0] dc_value = {dc_high_value[DC_HIGH_W-1:0], dc_low_value};
  assign left_primary_dc_dither_o = dc_value;

  // one lsb of q0.11 is 2^-16 of full scale on a 24-bit word
  wire [MOD_W-1:0] dc_offset = {{DC_PAD{1'b0}}, dc_value, {DC_SHIFT{1'b0}}};
  wire [MOD_W:0] mod_sum = {left_mod_i[MOD_W-1], left_mod_i} + {1'b0, dc_offset};
  // offset is never negative, so only the positive rail can be crossed
  // wrapping would turn a near-full-scale sample into a large negative one
  wire mod_ovf = mod_sum[MOD_W] != mod_sum[MOD_W-1];
  wire [MOD_W-1:0] mod_next = mod_ovf ? MOD_POS_MAX : mod_sum[MOD_W-1:0];

  // dithered word registered every clock, one cycle of latency
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mod_reg <= '0;
    end else begin
      mod_reg <= mod_next;
    end
  end

  assign left_mod_o = mod_reg;
endmodule
